// >>> spi_eeprom_command_protect.sv
// command decode, status register, protection and page programming of a
// 2048-byte serial eeprom seen from behind its pins
// assumes the host drives cs_n, sck and si slow enough for 2-flop sampling
//
// Notes on behaviour
// - write-disable clears the latch only when cs rises after clock 8
// - write-disable with any clock count other than 8 is dropped
// - latch clears on reset, supply drop, write-disable, programming end
// - status byte repeats while cs stays low; cs high ends it
// - status read always allowed; latch and busy are live bits
// - status write changes only disable and block bits; 6..4 read zero
// - status write needs the latch set, else ignored
// - status programming starts on cs rise after the data byte
// - status write with clock count other than 16 is dropped
// - old protection values stay in force until programming ends
// - disable bit 0 permits status writes whatever the protect pin
// - disable 1 and protect pin low refuses status writes
// - protect pin high leaves only block protection in force
// - block codes protect none, 600h-7ffh, 400h-7ffh, all
// - memory read loads address, outputs byte, then increments
// - read address wraps from last location to zero
// - top five address bits are ignored
// - memory read is refused while programming
// - write takes whole bytes; programming starts on cs rise
// - only low five address bits step, wrapping in the page
// - memory programming end clears busy and latch
// - write refused without latch, while busy, or in protected block
// - write dropped unless clock count is 24 plus 8 per byte
// - one-byte opcodes sent msb first
// - status layout: disable 7, block 3..2, latch 1, busy 0
// - write-enable sets the latch only on cs rise after clock 8
// - input sampled on rising sck, output changes after falling sck
`timescale 1ns/1ps
module spi_eeprom_command_protect #(
    parameter int PROG_CYCLES = spi_eeprom_pkg::PROG_CYCLES
) (
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    input  wire logic cs_n_in,
    input  wire logic sck_in,
    input  wire logic si_in,
    input  wire logic wp_n_in,
    input  wire logic supply_drop_in,
    output logic      so_out,
    output logic      so_oe_out,
    output logic      write_in_progress_out,
    output logic      write_enable_latch_out,
    output logic      hardware_protect_mode_out
);

    localparam int PROG_W = $clog2(PROG_CYCLES + 1);
    localparam int CW     = spi_eeprom_pkg::CNT_W;
    localparam int AW     = spi_eeprom_pkg::ADDR_W;
    localparam int PW     = spi_eeprom_pkg::PAGE_W;

    // pin synchronisers: cs_n, sck, si, wp_n, supply drop
    logic [4:0] pins_s;
    logic       cs_n_s;
    logic       sck_s;
    logic       si_s;
    logic       wp_n_s;
    logic       drop_s;

    // reset to the idle pin levels, so no false sck or cs edge follows reset
    pin_sync #(
        .WIDTH     (5),
        .RESET_VAL (5'h12)
    ) u_sync (
        .clk_in  (ref_clk_in),
        .rstn_in (rstn_in),
        .d_in    ({cs_n_in, sck_in, si_in, wp_n_in, supply_drop_in}),
        .q_out   (pins_s)
    );

    assign cs_n_s = pins_s[4];
    assign sck_s  = pins_s[3];
    assign si_s   = pins_s[2];
    assign wp_n_s = pins_s[1];
    assign drop_s = pins_s[0];

    logic sck_prev_q;
    logic cs_n_prev_q;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_prev_q  <= 1'b0;
            cs_n_prev_q <= 1'b1;
        end else begin
            sck_prev_q  <= sck_s;
            cs_n_prev_q <= cs_n_s;
        end
    end

    logic selected;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    assign selected = ~cs_n_s;
    assign sck_rise = selected & sck_s & ~sck_prev_q;
    assign sck_fall = selected & ~sck_s & sck_prev_q;
    assign cs_fall  = ~cs_n_s & cs_n_prev_q;
    assign cs_rise  = cs_n_s & ~cs_n_prev_q;

    // clock count and input shift register
    logic [CW-1:0] clk_cnt_q;
    logic [CW-1:0] cnt_next;
    logic [6:0]    rx_q;
    logic [7:0]    rx_byte;
    logic          byte_done;

    assign cnt_next  = (clk_cnt_q == '1) ? clk_cnt_q : clk_cnt_q + CW'(1);
    assign rx_byte   = {rx_q, si_s};
    // a saturated count never lands on a byte boundary again
    assign byte_done = sck_rise & (clk_cnt_q != '1) & (cnt_next[2:0] == 3'h0);

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clk_cnt_q <= '0;
            rx_q      <= '0;
        end else if (cs_fall) begin
            clk_cnt_q <= '0;
        end else if (sck_rise) begin
            clk_cnt_q <= cnt_next;
            rx_q      <= rx_byte[6:0];
        end
    end

    // status and programming state
    logic              wel_q;
    logic              wip_q;
    logic [2:0]        sr_nv_q;
    logic [2:0]        sr_pend_q;
    logic [2:0]        rd_nv_q;
    logic              prog_is_sr_q;
    logic [PROG_W-1:0] prog_cnt_q;
    logic [AW-PW-1:0]  prog_page_q;
    logic              prog_done;
    logic              hw_protect;

    assign prog_done  = wip_q & (prog_cnt_q == '0);
    assign hw_protect = sr_nv_q[2] & ~wp_n_s;

    function automatic logic [7:0] status_byte(input logic [2:0] nv,
                                               input logic       write_enable_latch,
                                               input logic       write_in_progress);
        logic [7:0] b;
        b = 8'h00;
        b[spi_eeprom_pkg::SR_DISABLE_BIT] = nv[2];
        b[spi_eeprom_pkg::SR_BP_HI_BIT]   = nv[1];
        b[spi_eeprom_pkg::SR_BP_LO_BIT]   = nv[0];
        b[spi_eeprom_pkg::SR_WEL_BIT]     = write_enable_latch;
        b[spi_eeprom_pkg::SR_WIP_BIT]     = write_in_progress;
        return b;
    endfunction

    function automatic logic in_block(input logic [1:0]    bp,
                                      input logic [AW-1:0] a);
        logic hit;
        unique case (bp)
            2'b00: hit = 1'b0;
            2'b01: hit = a >= spi_eeprom_pkg::BLOCK_QUARTER_BASE;
            2'b10: hit = a >= spi_eeprom_pkg::BLOCK_HALF_BASE;
            2'b11: hit = a >= spi_eeprom_pkg::BLOCK_ALL_BASE;
        endcase
        return hit;
    endfunction

    // command mode
    spi_eeprom_pkg::cmd_mode_e mode_q;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_q <= spi_eeprom_pkg::MODE_IDLE;
        end else if (cs_fall) begin
            mode_q <= spi_eeprom_pkg::MODE_IDLE;
        end else if (byte_done && cnt_next == spi_eeprom_pkg::CNT_OPCODE) begin
            unique case (rx_byte)
                spi_eeprom_pkg::OP_SET_LATCH:
                    mode_q <= spi_eeprom_pkg::MODE_SET_LATCH;
                spi_eeprom_pkg::OP_CLEAR_LATCH:
                    mode_q <= spi_eeprom_pkg::MODE_CLEAR_LATCH;
                spi_eeprom_pkg::OP_STATUS_READ:
                    mode_q <= spi_eeprom_pkg::MODE_STATUS_READ;
                spi_eeprom_pkg::OP_STATUS_WRITE:
                    mode_q <= spi_eeprom_pkg::MODE_STATUS_WRITE;
                spi_eeprom_pkg::OP_MEM_READ:
                    mode_q <= wip_q ? spi_eeprom_pkg::MODE_IGNORE
                                    : spi_eeprom_pkg::MODE_MEM_READ;
                spi_eeprom_pkg::OP_MEM_WRITE:
                    mode_q <= spi_eeprom_pkg::MODE_MEM_WRITE;
                // unknown opcodes behave as a deselect
                default:
                    mode_q <= spi_eeprom_pkg::MODE_IGNORE;
            endcase
        end
    end

    logic is_read;
    logic is_write;
    logic is_sr_write;

    assign is_read     = mode_q == spi_eeprom_pkg::MODE_MEM_READ;
    assign is_write    = mode_q == spi_eeprom_pkg::MODE_MEM_WRITE;
    assign is_sr_write = mode_q == spi_eeprom_pkg::MODE_STATUS_WRITE;

    // address counter and page buffer
    logic [7:0]      mem_q [spi_eeprom_pkg::MEM_BYTES];
    logic [AW-1:0]   addr_q;
    logic [AW-1:0]   addr_full;
    logic [7:0]      page_q [spi_eeprom_pkg::PAGE_BYTES];
    logic [31:0]     page_vld_q;

    assign addr_full = {addr_q[AW-1:8], rx_byte};

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            addr_q <= '0;
        end else if (byte_done && (is_read || is_write)) begin
            if (cnt_next == spi_eeprom_pkg::CNT_ADDR_HI) begin
                addr_q[AW-1:8] <= rx_byte[AW-9:0];
            end else if (cnt_next == spi_eeprom_pkg::CNT_ADDR_LO) begin
                // reads keep the next address ready for the reload
                addr_q <= is_read ? addr_full + AW'(1) : addr_full;
            end else if (cnt_next > spi_eeprom_pkg::CNT_ADDR_LO) begin
                if (is_read) begin
                    addr_q <= addr_q + AW'(1);
                end else if (!wip_q) begin
                    addr_q[PW-1:0] <= addr_q[PW-1:0] + PW'(1);
                end
            end
        end
    end

    // page buffer is frozen while busy so a queued page is not disturbed
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            page_vld_q <= '0;
            for (int i = 0; i < spi_eeprom_pkg::PAGE_BYTES; i++) begin
                page_q[i] <= spi_eeprom_pkg::MEM_RESET;
            end
        end else if (byte_done && is_write && !wip_q) begin
            if (cnt_next == spi_eeprom_pkg::CNT_ADDR_LO) begin
                page_vld_q <= '0;
            end else if (cnt_next > spi_eeprom_pkg::CNT_ADDR_LO) begin
                page_q[addr_q[PW-1:0]]     <= rx_byte;
                page_vld_q[addr_q[PW-1:0]] <= 1'b1;
            end
        end
    end

    // status write data
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sr_pend_q <= spi_eeprom_pkg::SR_NV_RESET;
        end else if (byte_done && is_sr_write && !wip_q &&
                     cnt_next == spi_eeprom_pkg::CNT_STATUS_WRITE) begin
            sr_pend_q <= {rx_byte[spi_eeprom_pkg::SR_DISABLE_BIT],
                          rx_byte[spi_eeprom_pkg::SR_BP_HI_BIT],
                          rx_byte[spi_eeprom_pkg::SR_BP_LO_BIT]};
        end
    end

    // end-of-frame decisions
    logic start_sr;
    logic start_mem;

    assign start_sr  = cs_rise & is_sr_write & wel_q & ~wip_q & ~hw_protect
                     & (clk_cnt_q == spi_eeprom_pkg::CNT_STATUS_WRITE);
    assign start_mem = cs_rise & is_write & wel_q & ~wip_q
                     & ~in_block(sr_nv_q[1:0], addr_q)
                     & (clk_cnt_q >= spi_eeprom_pkg::CNT_FIRST_DATA)
                     & (clk_cnt_q[2:0] == 3'h0) & (clk_cnt_q != '1);

    // programming timer
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wip_q        <= 1'b0;
            prog_cnt_q   <= '0;
            prog_is_sr_q <= 1'b0;
            prog_page_q  <= '0;
        end else if (drop_s) begin
            wip_q <= 1'b0;
        end else if (start_sr || start_mem) begin
            wip_q        <= 1'b1;
            prog_cnt_q   <= PROG_W'(PROG_CYCLES - 1);
            prog_is_sr_q <= start_sr;
            prog_page_q  <= addr_q[AW-1:PW];
        end else if (prog_done) begin
            wip_q <= 1'b0;
        end else if (wip_q) begin
            prog_cnt_q <= prog_cnt_q - PROG_W'(1);
        end
    end

    // write enable latch
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wel_q <= 1'b0;
        end else if (drop_s || prog_done) begin
            wel_q <= 1'b0;
        end else if (cs_rise && clk_cnt_q == spi_eeprom_pkg::CNT_OPCODE) begin
            if (mode_q == spi_eeprom_pkg::MODE_SET_LATCH) begin
                wel_q <= 1'b1;
            end else if (mode_q == spi_eeprom_pkg::MODE_CLEAR_LATCH) begin
                wel_q <= 1'b0;
            end
        end
    end

    // nonvolatile status bits change only when programming ends
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sr_nv_q <= spi_eeprom_pkg::SR_NV_RESET;
        end else if (prog_done && prog_is_sr_q && !drop_s) begin
            sr_nv_q <= sr_pend_q;
        end
    end

    // memory array; reset stands in for the factory-erased state
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < spi_eeprom_pkg::MEM_BYTES; i++) begin
                mem_q[i] <= spi_eeprom_pkg::MEM_RESET;
            end
        end else if (prog_done && !prog_is_sr_q && !drop_s) begin
            for (int i = 0; i < spi_eeprom_pkg::PAGE_BYTES; i++) begin
                if (page_vld_q[i]) begin
                    mem_q[{prog_page_q, PW'(i)}] <= page_q[i];
                end
            end
        end
    end

    // serial output
    logic [7:0] tx_q;
    logic       tx_active_q;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_q        <= '0;
            tx_active_q <= 1'b0;
            rd_nv_q     <= spi_eeprom_pkg::SR_NV_RESET;
        end else if (!selected) begin
            tx_active_q <= 1'b0;
        end else if (byte_done) begin
            if (cnt_next == spi_eeprom_pkg::CNT_OPCODE) begin
                if (rx_byte == spi_eeprom_pkg::OP_STATUS_READ) begin
                    // protection bits frozen for this read only
                    rd_nv_q     <= sr_nv_q;
                    tx_q        <= status_byte(sr_nv_q, wel_q, wip_q);
                    tx_active_q <= 1'b1;
                end
            end else if (mode_q == spi_eeprom_pkg::MODE_STATUS_READ) begin
                tx_q <= status_byte(rd_nv_q, wel_q, wip_q);
            end else if (is_read && cnt_next == spi_eeprom_pkg::CNT_ADDR_LO) begin
                tx_q        <= mem_q[addr_full];
                tx_active_q <= 1'b1;
            end else if (is_read && cnt_next > spi_eeprom_pkg::CNT_ADDR_LO) begin
                tx_q <= mem_q[addr_q];
            end
        end else if (sck_fall && tx_active_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            so_out    <= 1'b0;
            so_oe_out <= 1'b0;
        end else if (!selected) begin
            so_oe_out <= 1'b0;
        end else if (sck_fall && tx_active_q) begin
            so_out    <= tx_q[7];
            so_oe_out <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            write_in_progress_out     <= 1'b0;
            write_enable_latch_out    <= 1'b0;
            hardware_protect_mode_out <= 1'b0;
        end else begin
            write_in_progress_out     <= wip_q;
            write_enable_latch_out    <= wel_q;
            hardware_protect_mode_out <= hw_protect;
        end
    end

endmodule

// >>> spi_eeprom_pkg.sv
// constants, opcodes and command modes of the serial eeprom command block
// assumes one 40 MHz system clock samples every link pin
package spi_eeprom_pkg;

    localparam int ADDR_W     = 11;
    localparam int MEM_BYTES  = 2048;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W     = 5;
    localparam int CNT_W      = 16;

    localparam logic [7:0] OP_SET_LATCH    = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ     = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE    = 8'h02;

    localparam int SR_DISABLE_BIT = 7;
    localparam int SR_BP_HI_BIT   = 3;
    localparam int SR_BP_LO_BIT   = 2;
    localparam int SR_WEL_BIT     = 1;
    localparam int SR_WIP_BIT     = 0;

    // nonvolatile status field: {disable, bp_hi, bp_lo}
    localparam logic [2:0] SR_NV_RESET = 3'h0;
    localparam logic [7:0] MEM_RESET   = 8'hff;

    localparam logic [15:0] CNT_OPCODE       = 16'h0008;
    localparam logic [15:0] CNT_STATUS_WRITE = 16'h0010;
    localparam logic [15:0] CNT_ADDR_HI      = 16'h0010;
    localparam logic [15:0] CNT_ADDR_LO      = 16'h0018;
    localparam logic [15:0] CNT_FIRST_DATA   = 16'h0020;

    localparam logic [10:0] BLOCK_QUARTER_BASE = 11'h600;
    localparam logic [10:0] BLOCK_HALF_BASE    = 11'h400;
    localparam logic [10:0] BLOCK_ALL_BASE     = 11'h000;

    localparam int PROG_TIME_NS  = 5000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MODE_IDLE         = 3'b000,
        MODE_SET_LATCH    = 3'b001,
        MODE_CLEAR_LATCH  = 3'b010,
        MODE_STATUS_READ  = 3'b011,
        MODE_STATUS_WRITE = 3'b100,
        MODE_MEM_READ     = 3'b101,
        MODE_MEM_WRITE    = 3'b110,
        MODE_IGNORE       = 3'b111
    } cmd_mode_e;

endpackage

// >>> pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= RESET_VAL;
            q_out  <= RESET_VAL;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule

// >>> spi_eeprom_command_protect_properties.sv
// assertion checker for the serial eeprom command block, bound to its top
// assumes it sees only the top ports, all in the ref_clk_in domain
`timescale 1ns/1ps
module spi_eeprom_command_protect_checker #(
    parameter int PROG_CYCLES = spi_eeprom_pkg::PROG_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    input wire logic supply_drop_in,
    input wire logic so_out,
    input wire logic so_oe_out,
    input wire logic write_in_progress_out,
    input wire logic write_enable_latch_out,
    input wire logic hardware_protect_mode_out
);
    int   busy_len_q;
    int   fall_age_q;
    logic sck_q;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    // age since the raw pin fell, so the design's sync delay is allowed for
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_q      <= 1'b0;
            fall_age_q <= 0;
        end else begin
            sck_q      <= sck_in;
            fall_age_q <= (sck_q && !sck_in) ? 0 : (fall_age_q < 15) ? fall_age_q + 1 : 15;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_len_q <= 0;
        end else begin
            busy_len_q <= write_in_progress_out ? busy_len_q + 1 : 0;
        end
    end

    oe_idle_a: assert property (cs_n_in [*6] |-> !so_oe_out)
        else $error("serial output enabled while deselected");
    oe_select_a: assert property ($rose(so_oe_out) |-> !cs_n_in)
        else $error("serial output enabled outside a frame");
    so_edge_a: assert property (
        so_oe_out && $past(so_oe_out) && $changed(so_out) |-> fall_age_q <= 6)
        else $error("serial output changed away from a falling clock");
    hpm_release_a: assert property (wp_n_in [*6] |-> !hardware_protect_mode_out)
        else $error("hardware protection with protect pin high");
    drop_latch_a: assert property (supply_drop_in [*6] |-> !write_enable_latch_out)
        else $error("latch survived a supply drop");
    latch_set_a: assert property ($rose(write_enable_latch_out) |-> cs_n_in)
        else $error("latch set inside a frame");
    prog_start_a: assert property ($rose(write_in_progress_out) |->
        cs_n_in && write_enable_latch_out)
        else $error("programming started without deselect or latch");
    prog_len_a: assert property ($fell(write_in_progress_out) |->
        busy_len_q >= PROG_CYCLES - 1 && busy_len_q <= PROG_CYCLES + 2)
        else $error("programming time wrong");
    prog_end_a: assert property ($fell(write_in_progress_out) |-> !write_enable_latch_out)
        else $error("latch still set after programming");
endmodule

bind spi_eeprom_command_protect spi_eeprom_command_protect_checker #(
    .PROG_CYCLES(PROG_CYCLES)
) i_checker (
    .ref_clk_in, .rstn_in, .cs_n_in, .sck_in, .si_in, .wp_n_in, .supply_drop_in, .so_out,
    .so_oe_out, .write_in_progress_out, .write_enable_latch_out, .hardware_protect_mode_out
);

// >>> spi_host_model.sv
// host model: drives chip select, serial clock and data, collects so
// assumes 8 system clocks make one 200 ns link clock
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk_in,
    input  wire logic so_in,
    input  wire logic so_oe_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out
);
    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b0;
        si_out   = 1'b0;
    end

    // one frame of nbits link clocks, mode 0; sck stands low between frames
    task automatic frame(input logic [7:0] tx[$], input int nbits,
                         output logic [7:0] rx[$], output logic oe_seen);
        logic [7:0] sh;
        sh = 8'h00;
        rx = {};
        oe_seen = 1'b0;
        cs_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < nbits; i++) begin
            si_out <= (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : 1'b0;
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sh = {sh[6:0], so_in};
            oe_seen = oe_seen | so_oe_in;
            if (i % 8 == 7) rx.push_back(sh);
            sck_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        // deselect only after the last fall; released si shows the inverse
        cs_n_out <= 1'b1;
        si_out   <= ~si_out;
        repeat (6) @(posedge clk_in);
    endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the serial eeprom command block
// assumes spi_host_model drives the link and the checker is bound in
`timescale 1ns/1ps
module tb_top;
    localparam int PROG = 1000;

    logic        ref_clk, rstn, wp_n, supply_drop;
    logic        cs_n, sck, si, so, so_oe, busy, latch, hardware_protect_mode, oe_seen;
    int          failures;
    int          num_checks;
    logic [7:0]  rx_q [$];
    logic [7:0]  page_q [$];
    logic [7:0]  mem_m [2048];
    logic [10:0] addrs [3] = '{11'h3ff, 11'h5ff, 11'h600};

    spi_eeprom_command_protect #(.PROG_CYCLES(PROG)) i_dut (
        .ref_clk_in(ref_clk), .rstn_in(rstn), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
        .wp_n_in(wp_n), .supply_drop_in(supply_drop), .so_out(so), .so_oe_out(so_oe),
        .write_in_progress_out(busy), .write_enable_latch_out(latch),
        .hardware_protect_mode_out(hardware_protect_mode)
    );
    spi_host_model i_host (
        .clk_in(ref_clk), .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n), .sck_out(sck),
        .si_out(si)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic xfer(input logic [7:0] tx[$], input int nb);
        i_host.frame(tx, nb, rx_q, oe_seen);
    endtask

    task automatic set_write_latch_cmd();
        xfer({spi_eeprom_pkg::OP_SET_LATCH}, 8);
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge ref_clk);
        if (n == 2000) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic rd_sr(input logic [7:0] exp);
        xfer({spi_eeprom_pkg::OP_STATUS_READ, 8'h00, 8'h00}, 24);
        chk(rx_q[1], exp);
        chk(rx_q[2], exp);
        chk(8'(oe_seen), 8'h01);
    endtask

    task automatic set_sr(input logic [7:0] v);
        set_write_latch_cmd();
        xfer({spi_eeprom_pkg::OP_STATUS_WRITE, v}, 16);
        wait_idle();
    endtask

    task automatic mem_wr(input logic [15:0] a, input logic [7:0] d[$], input int extra);
        xfer({spi_eeprom_pkg::OP_MEM_WRITE, a[15:8], a[7:0], d}, 24 + 8 * d.size() + extra);
    endtask

    task automatic mem_rd_chk(input logic [10:0] a, input int n);
        logic [10:0] ak;
        xfer({spi_eeprom_pkg::OP_MEM_READ, 8'(a[10:8]), a[7:0]}, 24 + 8 * n);
        for (int k = 0; k < n; k++) begin
            ak = a + 11'(k);
            chk(rx_q[3 + k], mem_m[ak]);
        end
    endtask

    // refused writes leave the latch set, so every write but the first status write and the busy-refused write to 0020h is preceded by set_write_latch_cmd
    initial begin
        rstn = 1'b0;
        wp_n = 1'b1;
        supply_drop = 1'b0;
        failures = 0;
        num_checks = 0;
        foreach (mem_m[i]) mem_m[i] = 8'hff;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_sr(8'h00);
        set_write_latch_cmd();
        chk(8'(latch), 8'h01);
        xfer({spi_eeprom_pkg::OP_CLEAR_LATCH}, 9);
        chk(8'(latch), 8'h01);
        xfer({spi_eeprom_pkg::OP_CLEAR_LATCH}, 8);
        chk(8'(latch), 8'h00);
        $display("latch test done");
        xfer({spi_eeprom_pkg::OP_STATUS_WRITE, 8'hfc}, 16);
        chk(8'(busy), 8'h00);
        set_write_latch_cmd();
        xfer({spi_eeprom_pkg::OP_STATUS_WRITE, 8'hfc}, 16);
        rd_sr(8'h03);
        wait_idle();
        rd_sr(8'h8c);
        set_write_latch_cmd();
        xfer({spi_eeprom_pkg::OP_STATUS_WRITE, 8'h00}, 17);
        rd_sr(8'h8e);
        wp_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(8'(hardware_protect_mode), 8'h01);
        set_write_latch_cmd();
        xfer({spi_eeprom_pkg::OP_STATUS_WRITE, 8'h00}, 16);
        chk(8'(busy), 8'h00);
        wp_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk(8'(hardware_protect_mode), 8'h00);
        set_sr(8'h04);
        wp_n <= 1'b0;
        set_sr(8'h08);
        rd_sr(8'h08);
        wp_n <= 1'b1;
        $display("status test done");
        for (int bp = 0; bp < 4; bp++) begin
            set_sr(8'(bp * 4));
            foreach (addrs[j]) begin
                set_write_latch_cmd();
                mem_wr(16'hf800 | 16'(addrs[j]), {8'(bp * 16 + j)}, 0);
                wait_idle();
                if (!(bp == 3 || (bp == 2 && addrs[j] >= spi_eeprom_pkg::BLOCK_HALF_BASE) ||
                      (bp == 1 && addrs[j] >= spi_eeprom_pkg::BLOCK_QUARTER_BASE)))
                    mem_m[addrs[j]] = 8'(bp * 16 + j);
                mem_rd_chk(addrs[j], 1);
            end
        end
        set_sr(8'h00);
        $display("protect test done");
        for (int k = 0; k < 33; k++) begin
            page_q.push_back(8'(64 + k));
            mem_m[11'h7e0 | 11'((30 + k) % 32)] = 8'(64 + k);
        end
        set_write_latch_cmd();
        mem_wr(16'h07fe, page_q, 0);
        wait_idle();
        mem_rd_chk(11'h7fe, 4);
        set_write_latch_cmd();
        mem_wr(16'h0100, {8'h5a}, 1);
        chk(8'(busy), 8'h00);
        mem_rd_chk(11'h100, 1);
        set_write_latch_cmd();
        mem_wr(16'h0010, {8'h11}, 0);
        mem_wr(16'h0020, {8'h22}, 0);
        xfer({spi_eeprom_pkg::OP_MEM_READ, 8'h00, 8'h10}, 32);
        chk(8'(oe_seen), 8'h00);
        wait_idle();
        mem_m[11'h010] = 8'h11;
        mem_rd_chk(11'h010, 1);
        mem_rd_chk(11'h020, 1);
        chk(8'(latch), 8'h00);
        set_write_latch_cmd();
        supply_drop <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(8'(latch), 8'h00);
        supply_drop <= 1'b0;
        $display("memory test done");
        wrap_up();
    end
endmodule
